// >>> testbench/ssfe_engine_asserts.sv
// Concurrent checks on the frame engine pins
`timescale 1ns/100ps
module ssfe_engine_asserts #(
    parameter int WORD_W = 16,
    parameter int DEPTH = 8
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst, // Async reset
    input wire logic [1:0] i_format, // Frame format
    input wire logic i_clock_phase, // Clock phase
    input wire logic [3:0] i_word_len, // Bits minus one
    input wire logic [7:0] i_half_div, // Half bit divider
    input wire logic o_sclk, // Serial clock
    input wire logic o_sel_n, // Select, low active
    input wire logic o_mosi, // Data out
    input wire logic o_mosi_oe, // Data out enable
    input wire logic o_busy // Frame in progress
);
    logic sclk_q;
    logic [9:0] lo_time;
    logic [9:0] hi_time;
    logic [6:0] falls;
    logic [6:0] rises;
    wire logic [9:0] half = {2'b00, i_half_div} + 10'd1;
    wire logic fw = (i_format == 2'd0);
    wire logic hd = (i_format == 2'd1);

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    // ----
    // Cycle and edge counts inside each select-low span
    // ----
    // Counters restart whenever select is high, so spans never mix
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sclk_q <= 1'b1;
            lo_time <= 10'd0;
            hi_time <= 10'd0;
            falls <= 7'd0;
            rises <= 7'd0;
        end else begin
            sclk_q <= o_sclk;
            lo_time <= o_sel_n ? 10'd0 : lo_time + 10'd1;
            hi_time <= (o_sel_n || !o_sclk) ? 10'd0 : hi_time + 10'd1;
            falls <= o_sel_n ? 7'd0 : falls + {6'd0, sclk_q & !o_sclk};
            rises <= o_sel_n ? 7'd0 : rises + {6'd0, !sclk_q & o_sclk};
        end
    end

    // ----
    // Pin relations
    // ----
    a_idle_fourwire: assert property (
        fw && $past(fw) && !$past(i_rst) && !o_busy && !$past(o_busy)
        |-> o_sclk && o_sel_n && !o_mosi_oe)
        else $error("four-wire idle levels wrong");
    a_idle_halfdup: assert property (
        hd && $past(hd) && !$past(i_rst) && !o_busy && !$past(o_busy)
        |-> !o_sclk && o_sel_n && !o_mosi)
        else $error("half-duplex idle levels wrong");
    a_start_drives: assert property (
        $fell(o_sel_n) |-> (o_mosi_oe && o_busy && !o_sel_n) [*2])
        else $error("select fell without driving data");
    a_first_edge: assert property (
        fw && !o_sel_n && $fell(o_sclk) && falls == 7'd0
        |-> lo_time == (i_clock_phase ? half : {half[8:0], 1'b0}))
        else $error("first clock edge at wrong distance");
    a_end_hold: assert property (
        fw && $rose(o_sel_n)
        |-> hi_time == (i_clock_phase ? {half[8:0], 1'b0} : half))
        else $error("select released at wrong time");
    a_word_select: assert property (
        fw && !i_clock_phase && $rose(o_sel_n)
        |-> falls == {3'd0, i_word_len} + 7'd1)
        else $error("select span not one word");
    a_hd_frame: assert property (
        hd && $rose(o_sel_n)
        |-> rises != 7'd0 && rises % ({3'd0, i_word_len} + 7'd10) == 7'd0)
        else $error("half-duplex frame length wrong");
    a_mosi_edge: assert property (
        fw && !o_sel_n && (i_clock_phase ? $rose(o_sclk) : $fell(o_sclk))
        |-> $stable(o_mosi))
        else $error("data moved on capture edge");
    a_hd_edge: assert property (
        hd && !o_sel_n && $rose(o_sclk) |-> $stable(o_mosi))
        else $error("control data moved on rising edge");
endmodule : ssfe_engine_asserts

bind ssfe_engine ssfe_engine_asserts #(.WORD_W(WORD_W), .DEPTH(DEPTH))
    ssfe_engine_asserts_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_format(i_format), .i_clock_phase(i_clock_phase),
    .i_word_len(i_word_len), .i_half_div(i_half_div), .o_sclk(o_sclk),
    .o_sel_n(o_sel_n), .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe),
    .o_busy(o_busy));

// >>> testbench/ssfe_slave_model.sv
// Behavioural off-chip serial slave facing the frame engine
`timescale 1ns/100ps
module ssfe_slave_model (
    input wire logic i_sclk, // Serial clock from engine
    input wire logic i_sel_n, // Select, low active
    input wire logic i_mosi, // Data from engine
    input wire logic i_hd, // Half-duplex format
    input wire logic i_phase, // Four-wire clock phase
    input wire logic [3:0] i_len, // Reply bits minus one
    input wire logic [15:0] i_reply, // Word to answer with
    output logic o_miso = 1'b0, // Reply data
    output logic [15:0] o_got = 16'h0000 // Bits taken from engine
);
    int n = 0;
    int r = 0;

    // ----
    // Select edges
    // ----
    always @(negedge i_sel_n) begin
        n = 0;
        r = 0;
        if (!i_hd && !i_phase) o_miso = i_reply[i_len];
    end
    // Released line flips so a stale value never passes for data
    always @(posedge i_sel_n) o_miso = ~o_miso;

    // ----
    // Clock edges
    // ----
    always @(i_sclk) begin
        if (!i_sel_n && i_hd) begin
            if (i_sclk) begin
                r = r + 1;
                if (r <= 8) o_got = {o_got[14:0], i_mosi};
                if (r == i_len + 10) r = 0;
            end else if (r >= 9) begin
                o_miso = i_reply[i_len + 9 - r];
            end else if (r == 0) begin
                o_miso = ~o_miso;
            end
        end else if (!i_sel_n) begin
            if (i_sclk == i_phase) begin
                o_got = {o_got[14:0], i_mosi};
                n = (n == i_len) ? 0 : n + 1;
            end else begin
                o_miso = i_reply[i_len - n];
            end
        end
    end
endmodule : ssfe_slave_model

// >>> testbench/tb_sync_serial_frame_engine.sv
// Self-checking bench for the synchronous serial frame engine
`timescale 1ns/100ps
module tb_sync_serial_frame_engine;
    localparam logic [15:0] ANSWER = 16'h9e71;
    localparam logic [7:0] SLV_PAT = 8'h5a;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic enable = 1'b1;
    logic phase = 1'b0;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic slv_sclk = 1'b0;
    logic slv_sel_n = 1'b1;
    logic slv_miso = 1'b1;
    logic [1:0] fmt = 2'd0;
    logic [3:0] len = 4'h7;
    logic [15:0] tx_data = 16'h0000;
    logic tx_ready, rx_valid, sclk, sel_n, mosi, mosi_oe, busy;
    logic miso, mdl_miso;
    logic [15:0] rx_data, got;
    int bad_count = 0;
    int n_compared = 0;

    // Slave-mode data comes from the bench, otherwise from the model
    assign miso = (fmt == 2'd2) ? slv_miso : mdl_miso;

    ssfe_engine #(.WORD_W(16), .DEPTH(8)) ssfe_engine_inst (
        .i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_enable(enable),
        .i_format(fmt), .i_clock_phase(phase), .i_word_len(len),
        .i_half_div(8'h03), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
        .i_tx_data(tx_data), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
        .o_rx_data(rx_data), .o_sclk(sclk), .o_sel_n(sel_n), .o_mosi(mosi),
        .o_mosi_oe(mosi_oe), .i_miso(miso), .i_slv_sclk(slv_sclk),
        .i_slv_sel_n(slv_sel_n), .o_busy(busy));

    ssfe_slave_model ssfe_slave_model_inst (.i_sclk(sclk), .i_sel_n(sel_n),
        .i_mosi(mosi), .i_hd(fmt == 2'd1), .i_phase(phase), .i_len(len),
        .i_reply(ANSWER), .o_miso(mdl_miso), .o_got(got));

    // ----
    // Shared helpers
    // ----
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // Request held until the edge that sees ready high
    task automatic push(input logic [15:0] d);
        int k = 0;
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data <= d;
        do begin
            @(negedge clk);
            k++;
        end while (tx_ready !== 1'b1 && k < 4000);
        check({15'h0, tx_ready}, 16'h0001);
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask : push

    // Start lands one edge after the write, so give it a few first
    task automatic wait_idle();
        int k = 0;
        repeat (4) @(negedge clk);
        while (busy !== 1'b0 && k < 4000) begin @(negedge clk); k++; end
        check({15'h0, busy}, 16'h0000);
    endtask : wait_idle

    task automatic pop(input logic [15:0] exp, input logic [15:0] mask);
        int k = 0;
        while (rx_valid !== 1'b1 && k < 4000) begin @(negedge clk); k++; end
        check({15'h0, rx_valid}, 16'h0001);
        check(rx_data & mask, exp & mask);
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
        @(negedge clk);
    endtask : pop

    // ----
    // Scenarios
    // ----
    task automatic t_four_wire(input logic p, input logic [3:0] l);
        logic [15:0] mask;
        mask = 16'hffff >> (4'hf - l);
        @(posedge clk);
        phase <= p;
        len <= l;
        push(16'ha5c3);
        push(16'h3c96);
        wait_idle();
        check(got & mask, 16'h3c96 & mask);
        pop(ANSWER, mask);
        pop(ANSWER, mask);
    endtask : t_four_wire

    task automatic t_half_duplex();
        @(posedge clk);
        fmt <= 2'd1;
        len <= 4'h3;
        repeat (4) @(posedge clk);
        push(16'h00a6);
        wait_idle();
        check(got & 16'h00ff, 16'h00a6);
        pop(ANSWER, 16'h000f);
        @(posedge clk);
        len <= 4'hf;
        push(16'h00b3);
        push(16'h005d);
        wait_idle();
        check(got & 16'h00ff, 16'h005d);
        pop(ANSWER, 16'hffff);
        pop(ANSWER, 16'hffff);
        @(posedge clk);
        fmt <= 2'd0;
    endtask : t_half_duplex

    // Fill both buffers while the reader stalls, then drain them
    task automatic t_fill_drain();
        @(posedge clk);
        enable <= 1'b0;
        len <= 4'h3;
        phase <= 1'b0;
        for (int i = 0; i < 8; i++) push(16'(i));
        @(negedge clk);
        check({15'h0, tx_ready}, 16'h0000);
        check({15'h0, busy}, 16'h0000);
        @(posedge clk);
        enable <= 1'b1;
        push(16'h0009);
        wait_idle();
        check({15'h0, rx_valid}, 16'h0001);
        for (int i = 0; i < 9; i++) pop(ANSWER, 16'h000f);
        wait_idle();
        check(got & 16'h000f, 16'h0009);
        check({15'h0, rx_valid}, 16'h0000);
    endtask : t_fill_drain

    // Link clock of 40 system cycles, still outside the frame
    task automatic t_slave_receive();
        @(posedge clk);
        fmt <= 2'd2;
        len <= 4'h7;
        slv_sel_n <= 1'b0;
        repeat (80) @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            slv_miso <= SLV_PAT[i];
            repeat (20) @(posedge clk);
            slv_sclk <= 1'b1;
            repeat (20) @(posedge clk);
            slv_sclk <= 1'b0;
        end
        repeat (40) @(posedge clk);
        slv_sel_n <= 1'b1;
        slv_miso <= ~slv_miso;
        @(negedge clk);
        pop({8'h00, SLV_PAT}, 16'h00ff);
    endtask : t_slave_receive

    // ----
    // Clock, sequence and watchdog
    // ----
    initial begin
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({12'h0, sclk, sel_n, mosi_oe, busy}, 16'h000c);
        t_four_wire(1'b0, 4'h3);
        t_four_wire(1'b0, 4'hf);
        t_four_wire(1'b1, 4'h3);
        t_four_wire(1'b1, 4'hf);
        t_half_duplex();
        t_fill_drain();
        t_slave_receive();
        wrap_up();
    end

    // Whole run needs well under 25k cycles
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end
endmodule : tb_sync_serial_frame_engine

// >>> verilog/ssfe_engine.sv
// Frame engine: four-wire polarity-high modes and half-duplex format
`timescale 1ns/100ps
module ssfe_engine #(
    parameter int WORD_W = ssfe_pkg::SSFE_WORD_W,
    parameter int DEPTH = ssfe_pkg::SSFE_FIFO_DEPTH
) (
    input wire logic i_clk_sys, // 250 MHz system clock
    input wire logic i_rst, // Async reset, active high
    input wire logic i_ce, // Clock enable, freezes all
    input wire logic i_enable, // Port enable
    input wire logic [1:0] i_format, // ssfe_fmt_t value
    input wire logic i_clock_phase, // 0 first edge, 1 second
    input wire logic [3:0] i_word_len, // Bits minus one
    input wire logic [7:0] i_half_div, // Sys clocks per half bit, minus one
    input wire logic i_tx_valid, // Transmit word offered
    output logic o_tx_ready, // Transmit FIFO has room
    input wire logic [WORD_W-1:0] i_tx_data, // Transmit word
    output logic o_rx_valid, // Receive word available
    input wire logic i_rx_ready, // Receive word taken
    output logic [WORD_W-1:0] o_rx_data, // Received word
    output logic o_sclk, // Serial clock out
    output logic o_sel_n, // Slave select out, low active
    output logic o_mosi, // Serial data out
    output logic o_mosi_oe, // Serial data output enable
    input wire logic i_miso, // Serial data in (pin)
    input wire logic i_slv_sclk, // Clock from master (pin)
    input wire logic i_slv_sel_n, // Select from master (pin)
    output logic o_busy // Frame in progress
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_LEAD, ST_BIT_A, ST_BIT_B, ST_TAIL, ST_GAP
    } ssfe_state_t;

    ssfe_state_t state_reg;
    logic [7:0] tick_cnt_reg;
    logic [4:0] bit_cnt_reg;
    logic [WORD_W-1:0] tx_sh_reg;
    logic [WORD_W-1:0] rx_sh_reg;
    logic in_reply_reg;
    logic lead_half_reg;
    logic rx_push_reg;
    logic [WORD_W-1:0] rx_word_reg;
    logic tick;
    logic fmt_hd;
    logic fmt_slave;
    logic txf_valid;
    logic txf_pop;
    logic [WORD_W-1:0] txf_data;
    logic rxf_ready;
    logic miso_s;
    logic slv_sclk_s;
    logic slv_sel_n_s;
    logic slv_sclk_d_reg;
    logic [4:0] slv_cnt_reg;
    logic slv_sel_d_reg;
    logic [WORD_W-1:0] slv_sh_reg;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Msb of a word of programmable length
    function automatic logic msb_of(input logic [WORD_W-1:0] w,
                                    input logic [3:0] len);
        msb_of = w[len];
    endfunction : msb_of

    // ------------------------------------------------------------
    // Pin synchronisers and FIFOs
    // ------------------------------------------------------------
    // Idle levels: clock low, select high, so no false edge on release
    ssfe_sync #(.WIDTH(3), .INIT(3'h2)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_async({i_slv_sclk, i_slv_sel_n, i_miso}),
        .o_sync({slv_sclk_s, slv_sel_n_s, miso_s})
    );

    ssfe_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_txf (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_in_valid(i_tx_valid),
        .o_in_ready(o_tx_ready),
        .i_in_data(i_tx_data),
        .o_out_valid(txf_valid),
        .i_out_ready(txf_pop),
        .o_out_data(txf_data)
    );

    ssfe_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_rxf (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_in_valid(rx_push_reg),
        .o_in_ready(rxf_ready),
        .i_in_data(rx_word_reg),
        .o_out_valid(o_rx_valid),
        .i_out_ready(i_rx_ready),
        .o_out_data(o_rx_data)
    );

    assign fmt_hd = (i_format == 2'(ssfe_pkg::SSFE_FMT_HALFDUPLEX));
    assign fmt_slave = (i_format == 2'(ssfe_pkg::SSFE_FMT_HD_SLAVE));
    assign tick = (tick_cnt_reg == 8'h00);
    // Load the FIFO head as select falls; full receive FIFO stalls
    assign txf_pop = (state_reg == ST_IDLE || state_reg == ST_GAP)
                     && i_enable && !fmt_slave && txf_valid && rxf_ready
                     && (state_reg == ST_IDLE || tick);

    // ------------------------------------------------------------
    // Half-bit timebase
    // ------------------------------------------------------------
    // Divider restarts on frame start so the lead half is full length
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt_reg <= ssfe_pkg::SSFE_DIV_RESET;
        end else if (i_ce) begin
            if (state_reg == ST_IDLE || tick) begin
                tick_cnt_reg <= i_half_div;
            end else begin
                tick_cnt_reg <= tick_cnt_reg - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Master frame sequencer
    // ------------------------------------------------------------
    // LEAD: select low for half a period (a full one in phase zero);
    // BIT_A/BIT_B: two halves of each bit; TAIL: closing half after a
    // rising capture; GAP: between words (select high in phase zero).
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= '0;
            tx_sh_reg <= '0;
            rx_sh_reg <= '0;
            in_reply_reg <= 1'b0;
            lead_half_reg <= 1'b0;
        end else if (i_ce) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (txf_pop) begin
                        state_reg <= ST_LEAD;
                        tx_sh_reg <= txf_data;
                        in_reply_reg <= 1'b0;
                        lead_half_reg <= 1'b0;
                        bit_cnt_reg <= fmt_hd
                            ? 5'(ssfe_pkg::SSFE_CTRL_BITS - 1)
                            : {1'b0, i_word_len};
                    end
                end
                ST_LEAD: begin
                    // Data already valid; phase zero waits one more half
                    if (tick) begin
                        if (!fmt_hd && !i_clock_phase && !lead_half_reg) begin
                            lead_half_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_BIT_A;
                        end
                    end
                end
                ST_BIT_A: begin
                    // Phase zero opens and half duplex closes the first half
                    // with a capture edge; phase one: first half is launch
                    if (tick) begin
                        state_reg <= ST_BIT_B;
                        if (fmt_hd || !i_clock_phase) begin
                            rx_sh_reg <= {rx_sh_reg[WORD_W-2:0],
                                          miso_s};
                        end
                        if (!fmt_hd && !i_clock_phase) begin
                            // Phase zero changes data on the rising edge
                            tx_sh_reg <= {tx_sh_reg[WORD_W-2:0], 1'b0};
                        end
                    end
                end
                ST_BIT_B: begin
                    if (tick) begin
                        if (!fmt_hd && i_clock_phase) begin
                            rx_sh_reg <= {rx_sh_reg[WORD_W-2:0],
                                          miso_s};
                        end
                        if (fmt_hd || i_clock_phase) begin
                            tx_sh_reg <= {tx_sh_reg[WORD_W-2:0], 1'b0};
                        end
                        if (bit_cnt_reg != '0) begin
                            bit_cnt_reg <= bit_cnt_reg - 5'h01;
                            state_reg <= ST_BIT_A;
                        end else if (fmt_hd && !in_reply_reg) begin
                            // One wait clock then the reply
                            in_reply_reg <= 1'b1;
                            bit_cnt_reg <= {1'b0, i_word_len} + 5'h01;
                            state_reg <= ST_BIT_A;
                        end else if (txf_valid && i_enable
                                     && rxf_ready) begin
                            // Phase zero pulses select high here
                            state_reg <= ST_GAP;
                        end else if (fmt_hd || i_clock_phase) begin
                            state_reg <= ST_TAIL;
                        end else begin
                            // Falling capture was a full bit ago already
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_TAIL: begin
                    if (tick) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_GAP: begin
                    if (txf_pop) begin
                        tx_sh_reg <= txf_data;
                        in_reply_reg <= 1'b0;
                        lead_half_reg <= 1'b0;
                        bit_cnt_reg <= fmt_hd
                            ? 5'(ssfe_pkg::SSFE_CTRL_BITS - 1)
                            : {1'b0, i_word_len};
                        // Held-low modes go straight into next bit
                        state_reg <= (fmt_hd || i_clock_phase)
                                     ? ST_BIT_A : ST_LEAD;
                    end else if (tick) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive word hand-off
    // ------------------------------------------------------------
    // Master pushes at the word end; slave mode pushes its shifter
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rx_push_reg <= 1'b0;
            rx_word_reg <= '0;
        end else if (i_ce) begin
            rx_push_reg <= 1'b0;
            if (state_reg == ST_BIT_B && tick && bit_cnt_reg == '0
                && (!fmt_hd || in_reply_reg)) begin
                rx_push_reg <= 1'b1;
                rx_word_reg <= (!fmt_hd && i_clock_phase)
                    ? {rx_sh_reg[WORD_W-2:0], miso_s} : rx_sh_reg;
            end else if (fmt_slave && slv_sel_d_reg && slv_sel_n_s
                         && slv_cnt_reg != '0) begin
                rx_push_reg <= 1'b1;
                rx_word_reg <= slv_sh_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Half-duplex slave receive
    // ------------------------------------------------------------
    // Samples on every rising clock edge while select is low, so the
    // first sample is the first rising edge after select falls.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            slv_sclk_d_reg <= 1'b0;
            slv_sel_d_reg <= 1'b1;
            slv_cnt_reg <= '0;
            slv_sh_reg <= '0;
        end else if (i_ce) begin
            slv_sclk_d_reg <= slv_sclk_s;
            slv_sel_d_reg <= !slv_sel_n_s;
            if (!fmt_slave || slv_sel_n_s) begin
                slv_cnt_reg <= '0;
            end else if (slv_sclk_s && !slv_sclk_d_reg) begin
                slv_cnt_reg <= slv_cnt_reg + 5'h01;
                slv_sh_reg <= {slv_sh_reg[WORD_W-2:0], miso_s};
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Polarity is fixed high in four-wire modes, low in half duplex
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_sclk <= 1'b1;
            o_sel_n <= 1'b1;
            o_mosi <= 1'b0;
            o_mosi_oe <= 1'b0;
            o_busy <= 1'b0;
        end else if (i_ce) begin
            o_busy <= (state_reg != ST_IDLE);
            if (fmt_hd) begin
                // Rising edge in second half of each bit
                o_sclk <= (state_reg == ST_BIT_B);
                o_sel_n <= (state_reg == ST_IDLE);
                o_mosi_oe <= 1'b1;
                o_mosi <= (state_reg != ST_IDLE && !in_reply_reg)
                          ? tx_sh_reg[ssfe_pkg::SSFE_CTRL_BITS-1]
                          : 1'b0;
            end else begin
                // Idle high; phase zero falls in first half
                o_sclk <= !(state_reg == ST_BIT_A);
                o_sel_n <= (state_reg == ST_IDLE
                            || state_reg == ST_GAP && !i_clock_phase)
                            ;
                o_mosi_oe <= (state_reg != ST_IDLE && !fmt_slave);
                o_mosi <= msb_of(tx_sh_reg, i_word_len);
            end
        end
    end
endmodule : ssfe_engine

// >>> verilog/ssfe_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module ssfe_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst, // Async reset, active high
    input wire logic i_ce, // Clock enable
    input wire logic i_in_valid, // Write request
    output logic o_in_ready, // Not full
    input wire logic [WIDTH-1:0] i_in_data, // Write data
    output logic o_out_valid, // Not empty
    input wire logic i_out_ready, // Read request
    output logic [WIDTH-1:0] o_out_data // Head entry
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------
    assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem_reg[rd_ptr_reg];
    assign push = i_ce && i_in_valid && o_in_ready;
    assign pop = i_ce && i_out_ready && o_out_valid;

    // Storage; no reset so it maps to plain RAM
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    // Pointers wrap at depth
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                              : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                              : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : ssfe_fifo

// >>> verilog/ssfe_pkg.sv
// Constants and types for the synchronous serial frame engine
package ssfe_pkg;

    // ------------------------------------------------------------
    // Frame formats
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSFE_FMT_SPI_HI,
        SSFE_FMT_HALFDUPLEX,
        SSFE_FMT_HD_SLAVE,
        SSFE_FMT_RESERVED
    } ssfe_fmt_t;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int SSFE_WORD_W = 16;
    localparam int SSFE_CTRL_BITS = 8;
    localparam int SSFE_MIN_BITS = 4;
    localparam int SSFE_FIFO_DEPTH = 8;
    localparam logic [7:0] SSFE_DIV_RESET = 8'h02;
    localparam logic [3:0] SSFE_LEN_RESET = 4'h7;

endpackage : ssfe_pkg

// >>> verilog/ssfe_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ssfe_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst, // Async reset, active high
    input wire logic i_ce, // Clock enable
    input wire logic [WIDTH-1:0] i_async, // Pin levels
    output logic [WIDTH-1:0] o_sync // Synchronised levels
);
    logic [WIDTH-1:0] meta_reg;

    // First stage is read only by the second
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= INIT;
            o_sync <= INIT;
        end else if (i_ce) begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule : ssfe_sync
